/* File: design/pcix_status_defs.svh */
// Offsets, field positions, reset values and command codes for the bridge status block.
`ifndef PCIX_STATUS_DEFS_SVH
`define PCIX_STATUS_DEFS_SVH

`define REG_PRIMARY_BRIDGE_STATUS 8'h84
`define REG_UPSTREAM_SPLIT_COMMITMENT 8'h88

`define CMD_CFG_READ 4'ha
`define CMD_CFG_WRITE 4'hb
`define CFG_TYPE0 2'h0

`define FUNC_NUMBER_RESET 3'h0
`define DEV_NUMBER_RESET 5'h1f
`define BUS_NUMBER_RESET 8'hff

`define BIT_WIDE_64 16
`define BIT_CAP_133 17
`define BIT_SC_DISCARDED 18
`define BIT_UNEXP_SC 19
`define BIT_SC_OVERRUN 20
`define BIT_REQ_DELAYED 21

`define CAP_WIDE_64 1'h1
`define CAP_133 1'h1

`define SPLIT_CAPABILITY 16'h0010
`define SPLIT_LIMIT_RESET 16'h0010
`define SPLIT_LIMIT_UNLIMITED 16'hffff

`endif

/* File: design/pcix_status_pkg.sv */
// Types shared by the bridge status and split commitment logic.
package pcix_status_pkg;

    typedef struct packed {
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] func;
    } completer_id_s;

    typedef struct packed {
        logic valid;
        logic [3:0] cmd;
        logic idsel;
        logic [31:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } cfg_req_s;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } cfg_rsp_s;

    typedef struct packed {
        logic valid;
        logic [15:0] adq;
    } split_req_s;

    typedef struct packed {
        completer_id_s id;
        logic unexp_sc;
        logic req_delayed;
        logic [15:0] limit;
        cfg_rsp_s rsp;
    } status_state_s;

    typedef struct packed {
        logic [16:0] committed;
    } commit_state_s;

endpackage : pcix_status_pkg

/* File: design/split_commit_gate.sv */
// Tracks committed completion space and decides whether a split request may go on.
`timescale 1ns/1ns
`include "pcix_status_defs.svh"

module split_commit_gate
    import pcix_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [15:0] limit,
    input split_req_s req,
    input split_req_s release_adq,
    output logic forward,
    output logic delayed,
    output logic [16:0] committed
);

    commit_state_s state;
    commit_state_s next_state;
    logic [16:0] wanted;
    logic [16:0] freed;

    // ****************************************************************
    // Admission decision
    // ****************************************************************
    always_comb
    begin
        wanted = state.committed + {1'b0, req.adq};
        forward = req.valid && ((limit == `SPLIT_LIMIT_UNLIMITED) || (wanted <= {1'b0, limit}));
        delayed = req.valid && !forward;
        freed = release_adq.valid ? {1'b0, release_adq.adq} : 17'h00000;
        next_state = state;
        // Release is clamped so a stray completion cannot wrap the count below zero.
        if (freed > state.committed)
        begin
            next_state.committed = 17'h00000;
        end
        else
        begin
            next_state.committed = state.committed - freed;
        end
        if (forward)
        begin
            next_state.committed = next_state.committed + {1'b0, req.adq};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign committed = state.committed;

endmodule : split_commit_gate

/* File: design/pcix_bridge_status_split_limit.sv */
// Primary bridge status and upstream split commitment configuration registers.
//
// Overview of operation
// - Function number, bits 2:0, read-only, resets to zero.
// - Addressed config write loads device number bits 7:3 from AD[15:11]; resets ones.
// - Addressed means config write, IDSEL, AD[1:0]=00, AD[10:8] equals function.
// - Bits 15:8 mirror primary bus number register; reset all ones.
// - Split completion completer ID built from bus, device, function fields.
// - Same identity fields also used in conventional PCI mode.
// - Bit 16 reports a 64-bit primary interface.
// - Bit 17 reports 133MHz capable; writes never change it.
// - Bits 18 and 20 read-only, reset zero, writes ignored.
// - Bit 19 sets on split completion matching own ID; write one clears.
// - Bit 21 sets when a split request is delayed by limit; write one clears.
// - Bits 15:0 of upstream register read capability 0010h ADQs.
// - Bits 31:16 hold read-write commitment limit, reset 0010h.
// - Limit FFFFh forwards every split request regardless of space.
`timescale 1ns/1ns
`include "pcix_status_defs.svh"

module pcix_bridge_status_split_limit
    import pcix_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input cfg_req_s cfg_req,
    output cfg_rsp_s cfg_rsp,
    input wire logic [7:0] primary_bus_number,
    input split_req_s split_req,
    input split_req_s split_release,
    output logic split_forward,
    output logic split_delayed,
    output logic [16:0] split_committed,
    input wire logic split_cpl_valid,
    input completer_id_s split_cpl_requester,
    output completer_id_s completer_id
);

    status_state_s state;
    status_state_s next_state;
    logic type0_hit;
    logic cfg_write_hit;
    logic cfg_read_hit;
    logic [7:0] reg_offset;
    logic unexp_event;
    logic gate_delayed;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Register word offset of a type-0 configuration address.
    function automatic logic [7:0] word_offset(input logic [31:0] addr);
        word_offset = {addr[7:2], 2'b00};
    endfunction : word_offset

    // Builds the read image of the primary bridge status register.
    function automatic logic [31:0] status_image(input status_state_s s);
        logic [31:0] img;
        img = 32'h00000000;
        img[2:0] = s.id.func;
        img[7:3] = s.id.dev;
        img[15:8] = s.id.bus;
        img[`BIT_WIDE_64] = `CAP_WIDE_64;
        img[`BIT_CAP_133] = `CAP_133;
        img[`BIT_SC_DISCARDED] = 1'b0;
        img[`BIT_SC_OVERRUN] = 1'b0;
        img[`BIT_UNEXP_SC] = s.unexp_sc;
        img[`BIT_REQ_DELAYED] = s.req_delayed;
        status_image = img;
    endfunction : status_image

    // Builds the read image of the upstream split commitment register.
    function automatic logic [31:0] split_image(input status_state_s s);
        split_image = {s.limit, `SPLIT_CAPABILITY};
    endfunction : split_image

    // ****************************************************************
    // Commitment gate
    // ****************************************************************
    split_commit_gate u_gate (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .limit(state.limit),
        .req(split_req),
        .release_adq(split_release),
        .forward(split_forward),
        .delayed(gate_delayed),
        .committed(split_committed)
    );

    assign split_delayed = gate_delayed;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    always_comb
    begin
        type0_hit = cfg_req.valid && cfg_req.idsel && (cfg_req.addr[1:0] == `CFG_TYPE0) &&
                    (cfg_req.addr[10:8] == state.id.func);
        cfg_write_hit = type0_hit && (cfg_req.cmd == `CMD_CFG_WRITE);
        cfg_read_hit = type0_hit && (cfg_req.cmd == `CMD_CFG_READ);
        reg_offset = word_offset(cfg_req.addr);
        unexp_event = split_cpl_valid && (split_cpl_requester == state.id);
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        next_state.rsp.valid = 1'b0;

        next_state.id.bus = primary_bus_number;

        if (cfg_write_hit)
        begin
            // capture device number on any addressed write
            next_state.id.dev = cfg_req.addr[15:11];
            if (reg_offset == `REG_PRIMARY_BRIDGE_STATUS && cfg_req.byte_en[2])
            begin
                if (cfg_req.wdata[`BIT_UNEXP_SC])
                begin
                    next_state.unexp_sc = 1'b0;
                end
                if (cfg_req.wdata[`BIT_REQ_DELAYED])
                begin
                    next_state.req_delayed = 1'b0;
                end
            end
            if (reg_offset == `REG_UPSTREAM_SPLIT_COMMITMENT)
            begin
                // limit is read-write per byte lane
                if (cfg_req.byte_en[2])
                begin
                    next_state.limit[7:0] = cfg_req.wdata[23:16];
                end
                if (cfg_req.byte_en[3])
                begin
                    next_state.limit[15:8] = cfg_req.wdata[31:24];
                end
            end
        end

        // Setting events are applied after the clear so a simultaneous event is kept.
        // set unexpected completion
        if (unexp_event)
        begin
            next_state.unexp_sc = 1'b1;
        end
        if (gate_delayed)
        begin
            next_state.req_delayed = 1'b1;
        end

        if (cfg_read_hit)
        begin
            next_state.rsp.valid = 1'b1;
            case (reg_offset)
                `REG_PRIMARY_BRIDGE_STATUS:
                begin
                    next_state.rsp.data = status_image(state);
                end
                `REG_UPSTREAM_SPLIT_COMMITMENT:
                begin
                    next_state.rsp.data = split_image(state);
                end
                default:
                begin
                    // Offsets outside this block read as zero.
                    next_state.rsp.data = 32'h00000000;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state.id.func <= `FUNC_NUMBER_RESET;
            state.id.dev <= `DEV_NUMBER_RESET;
            state.id.bus <= `BUS_NUMBER_RESET;
            state.unexp_sc <= 1'b0;
            state.req_delayed <= 1'b0;
            state.limit <= `SPLIT_LIMIT_RESET;
            state.rsp <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign cfg_rsp = state.rsp;

    // The identity is offered as one word so the completion builder and the
    // conventional-mode path cannot drift apart.
    // completer ID source
    assign completer_id = state.id;

endmodule : pcix_bridge_status_split_limit

/* File: verif/pcix_status_properties.sv */
// Port-level assertions for the bridge status and split commitment block.
`timescale 1ns/1ns
`include "pcix_status_defs.svh"
module pcix_status_checker
    import pcix_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input cfg_req_s cfg_req,
    input cfg_rsp_s cfg_rsp,
    input wire logic [7:0] primary_bus_number,
    input split_req_s split_req,
    input split_req_s split_release,
    input wire logic split_forward,
    input wire logic split_delayed,
    input wire logic [16:0] split_committed,
    input wire logic split_cpl_valid,
    input completer_id_s split_cpl_requester,
    input completer_id_s completer_id
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    wire logic hit = cfg_req.valid && cfg_req.idsel && cfg_req.addr[1:0] == 2'h0 && cfg_req.addr[10:8] == 3'h0;
    wire logic rd = hit && cfg_req.cmd == `CMD_CFG_READ;
    wire logic wr = hit && cfg_req.cmd == `CMD_CFG_WRITE;
    wire logic [4:0] req_dev = cfg_req.addr[15:11];
    wire logic [7:0] offset = cfg_req.addr[7:0];
    wire logic [16:0] req_adq = {1'b0, split_req.adq};
    wire logic moved = split_req.valid && !split_release.valid;

    a_read_answer: assert property (!$past(sys_rst) |-> cfg_rsp.valid == $past(rd))
        else $error("read answer does not follow an addressed read");
    a_dev_load: assert property (wr |=> completer_id.dev == $past(req_dev))
        else $error("device number not loaded by an addressed write");
    a_dev_hold: assert property (!wr |=> $stable(completer_id.dev))
        else $error("device number changed without an addressed write");
    a_bus_mirror: assert property (!$past(sys_rst) |-> completer_id.bus == $past(primary_bus_number))
        else $error("bus number does not follow the header register");
    a_gate_onehot: assert property (split_req.valid |-> split_forward != split_delayed)
        else $error("split request not decided exactly once");
    a_commit_add: assert property (moved && split_forward |=>
        split_committed == $past(split_committed) + $past(req_adq))
        else $error("forwarded request not added to committed space");
    a_delay_keep: assert property (moved && split_delayed |=> $stable(split_committed))
        else $error("delayed request changed committed space");
    a_status_ro: assert property (rd && offset == `REG_PRIMARY_BRIDGE_STATUS |=>
        {cfg_rsp.data[31:22], cfg_rsp.data[20], cfg_rsp.data[18:16], cfg_rsp.data[2:0]} == 17'h00018)
        else $error("fixed status bits read wrong");
    a_split_cap: assert property (rd && offset == `REG_UPSTREAM_SPLIT_COMMITMENT |=>
        cfg_rsp.data[15:0] == 16'h0010)
        else $error("split capability field read wrong");
endmodule : pcix_status_checker

bind pcix_bridge_status_split_limit pcix_status_checker u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .primary_bus_number(primary_bus_number), .split_req(split_req), .split_release(split_release),
    .split_forward(split_forward), .split_delayed(split_delayed), .split_committed(split_committed),
    .split_cpl_valid(split_cpl_valid), .split_cpl_requester(split_cpl_requester), .completer_id(completer_id)
);

/* File: verif/cfg_host_model.sv */
// Primary-bus host model that issues configuration transactions.
`timescale 1ns/1ns
module cfg_host_model
    import pcix_status_pkg::*;
(
    input wire logic ref_clk,
    output cfg_req_s cfg_req,
    input cfg_rsp_s cfg_rsp
);
    initial cfg_req = '0;

    task automatic access(input logic [3:0] cmd, input logic idsel, input logic [31:0] addr,
        input logic [3:0] be, input logic [31:0] wdata, output logic rsp_v, output logic [31:0] rsp_d);
        @(posedge ref_clk);
        #1;
        cfg_req = '{1'b1, cmd, idsel, addr, be, wdata};
        @(posedge ref_clk);
        #1;
        // Released lines float, so the model shows the inverse rather than the last value.
        cfg_req = '{1'b0, ~cmd, ~idsel, ~addr, ~be, ~wdata};
        rsp_v = cfg_rsp.valid;
        rsp_d = cfg_rsp.data;
    endtask : access
endmodule : cfg_host_model

/* File: verif/pcix_bridge_status_split_limit_tb_top.sv */
// Self-checking bench for the bridge status and split commitment registers.
`timescale 1ns/1ns
module pcix_bridge_status_split_limit_tb_top
    import pcix_status_pkg::*;
;
    typedef struct packed {
        logic [3:0] cmd;
        logic idsel;
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
        logic exp_v;
        logic [31:0] exp_d;
    } row_s;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    cfg_req_s cfg_req;
    cfg_rsp_s cfg_rsp;
    logic [7:0] primary_bus_number = 8'h5a;
    split_req_s split_req = '0;
    split_req_s split_release = '0;
    logic split_forward;
    logic split_delayed;
    logic [16:0] split_committed;
    logic split_cpl_valid = 1'b0;
    completer_id_s split_cpl_requester = '0;
    completer_id_s completer_id;
    int error_cnt = 0;
    int samples_checked = 0;
    logic rv;
    logic [31:0] rd;
    row_s rows [13] = '{
        '{4'ha, 1'b1, 32'h84, 4'hf, 32'h0, 1'b1, 32'h0003_5af8},
        '{4'hb, 1'b1, 32'h1884, 4'hf, 32'hffff_ffff, 1'b0, 32'h0},
        '{4'ha, 1'b1, 32'h84, 4'hf, 32'h0, 1'b1, 32'h0003_5a18},
        '{4'hb, 1'b0, 32'h3884, 4'hf, 32'h0, 1'b0, 32'h0},
        '{4'hb, 1'b1, 32'h3885, 4'hf, 32'h0, 1'b0, 32'h0},
        '{4'hb, 1'b1, 32'h3984, 4'hf, 32'h0, 1'b0, 32'h0},
        '{4'ha, 1'b0, 32'h84, 4'hf, 32'h0, 1'b0, 32'h0},
        '{4'ha, 1'b1, 32'h84, 4'hf, 32'h0, 1'b1, 32'h0003_5a18},
        '{4'hb, 1'b1, 32'h888, 4'hc, 32'h1234_5678, 1'b0, 32'h0},
        '{4'ha, 1'b1, 32'h88, 4'hf, 32'h0, 1'b1, 32'h1234_0010},
        '{4'hb, 1'b1, 32'h888, 4'h4, 32'habcd_0000, 1'b0, 32'h0},
        '{4'ha, 1'b1, 32'h88, 4'hf, 32'h0, 1'b1, 32'h12cd_0010},
        '{4'ha, 1'b1, 32'h8c, 4'hf, 32'h0, 1'b1, 32'h0}};

    always #10 ref_clk = ~ref_clk;

    cfg_host_model u_host (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));
    pcix_bridge_status_split_limit u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .primary_bus_number(primary_bus_number), .split_req(split_req), .split_release(split_release),
        .split_forward(split_forward), .split_delayed(split_delayed), .split_committed(split_committed),
        .split_cpl_valid(split_cpl_valid), .split_cpl_requester(split_cpl_requester), .completer_id(completer_id));

    task automatic chk32(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk32

    task automatic chk1(input logic exp, input logic got);
        chk32({31'h0, exp}, {31'h0, got});
    endtask : chk1

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        u_host.access(4'ha, 1'b1, addr, 4'hf, 32'h0, rv, rd);
        chk1(1'b1, rv);
        chk32(exp, rd);
    endtask : rd_chk

    task automatic wr(input logic [31:0] addr, input logic [3:0] be, input logic [31:0] wdata);
        u_host.access(4'hb, 1'b1, addr, be, wdata, rv, rd);
    endtask : wr

    // The gate decides combinationally, so outputs are looked at while the request is held.
    task automatic spl(input logic [15:0] adq, input logic exp_fwd);
        @(posedge ref_clk);
        #1 split_req = '{1'b1, adq};
        #1 chk1(exp_fwd, split_forward);
        chk1(!exp_fwd, split_delayed);
        @(posedge ref_clk);
        #1 split_req.valid = 1'b0;
    endtask : spl

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        foreach (rows[i])
        begin
            u_host.access(rows[i].cmd, rows[i].idsel, rows[i].addr, rows[i].be, rows[i].wdata, rv, rd);
            chk1(rows[i].exp_v, rv);
            if (rows[i].exp_v)
                chk32(rows[i].exp_d, rd);
        end
        wr(32'h888, 4'hc, 32'h0010_0000);
        spl(16'h0010, 1'b1);
        spl(16'h0001, 1'b0);
        rd_chk(32'h84, 32'h0023_5a08);
        // Writes keep AD[15:11] at one so the captured device number stays put.
        wr(32'h884, 4'h4, 32'h0);
        rd_chk(32'h84, 32'h0023_5a08);
        wr(32'h884, 4'h4, 32'h0020_0000);
        rd_chk(32'h84, 32'h0003_5a08);
        @(posedge ref_clk);
        #1 split_release = '{1'b1, 16'h0010};
        @(posedge ref_clk);
        #1 split_release.valid = 1'b0;
        chk32(32'h0, {15'h0, split_committed});
        wr(32'h888, 4'hc, 32'hffff_0000);
        spl(16'h0010, 1'b1);
        spl(16'hffff, 1'b1);
        split_cpl_requester = '{8'h5a, 5'h2, 3'h0};
        split_cpl_valid = 1'b1;
        @(posedge ref_clk);
        #1 split_cpl_requester = '{8'h5a, 5'h1, 3'h0};
        @(posedge ref_clk);
        #1 split_cpl_valid = 1'b0;
        chk32(32'h0000_5a08, {16'h0, completer_id});
        rd_chk(32'h84, 32'h000b_5a08);
        wr(32'h884, 4'h4, 32'h0008_0000);
        rd_chk(32'h84, 32'h0003_5a08);
        primary_bus_number = 8'h3c;
        rd_chk(32'h84, 32'h0003_3c08);
        @(posedge ref_clk);
        #1 sys_rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        chk32(32'h0000_fff8, {16'h0, completer_id});
        chk32(32'h0, {15'h0, split_committed});
        #1 sys_rst = 1'b0;
        rd_chk(32'h84, 32'h0003_3cf8);
        rd_chk(32'h88, 32'h0010_0010);
        give_verdict();
    end
endmodule : pcix_bridge_status_split_limit_tb_top
